//--- verilog/coc_config_top.sv
// Our own choices: the APB slave port and the register addresses.
`default_nettype none
module coc_config_top
  import coc_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [coc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [coc_pkg::DATA_W-1:0] PWDATA,
  output logic [coc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Board pins
  input wire logic VCO_DIV_CLK,
  input wire logic OUTPUT_GATE_PIN,
  input wire logic ALIGN_N,
  input wire logic PD_FREQ_IN,
  // Clock outputs
  output logic [coc_pkg::NUM_CH-1:0] CLK_OUT,
  output logic LOCK_DETECT_CLK
);
  import coc_pkg::*;

  // Configuration words
  logic [31:0] chan_reg [NUM_CH];
  logic [31:0] prescale_reg;
  logic [31:0] pll_ctrl_reg;
  logic [31:0] feedback_reg;

  // Bus state
  coc_bus_e bus_state_reg;
  coc_bus_e bus_state_next;
  logic [31:0] rdata_next;
  logic err_next;
  logic [5:0] word_idx;
  logic addr_aligned;
  logic mapped;
  logic wr_commit;
  logic soft_reset;

  // Pin synchronisers
  logic [3:0] pin_meta_reg;
  logic [3:0] pin_sync_reg;
  logic vco_prev_reg;
  logic pd_prev_reg;
  logic vco_level;
  logic vco_rise;
  logic gate_level;
  logic align_hold;
  logic pd_level;
  logic pd_rise;

  // Channel controls
  logic [NUM_CH-1:0] eff_enable;
  logic all_outputs_enable;
  logic lock_detect_prescale;
  logic [NUM_CH-1:0] ch_clk;

  // Lock detect prescaler
  logic [0:0] pre_cnt_reg;
  logic pre_div_reg;

  // Word index from the byte address
  assign word_idx = PADDR[7:2];
  assign addr_aligned = (PADDR[1:0] == 2'h0);

  // Known words of the map
  always_comb
  begin
    mapped = 1'b0;
    if (addr_aligned)
    begin
      case (word_idx)
        IDX_RESET_WORD, IDX_OUTPUT0, IDX_OUTPUT1, IDX_OUTPUT2, IDX_OUTPUT3,
        IDX_LOCK_PRESCALE, IDX_PLL_CONTROL, IDX_FEEDBACK_DIV, IDX_STATUS:
          mapped = 1'b1;
        default:
          mapped = 1'b0;
      endcase
    end
  end

  // Access completes at the edge where the ready flop is high
  assign wr_commit = PSEL && PENABLE && PREADY && PWRITE && mapped;

  // Soft reset word wipes every stored configuration word
  assign soft_reset = wr_commit && word_idx == IDX_RESET_WORD
                      && PWDATA[SOFT_RESET_BIT];

  // Bus sequencing: one wait state, then ready
  always_comb
  begin
    bus_state_next = bus_state_reg;
    case (bus_state_reg)
      BUS_IDLE:
        if (PSEL && PENABLE)
          bus_state_next = BUS_WAIT;
      BUS_WAIT:
        bus_state_next = BUS_DONE;
      BUS_DONE:
        bus_state_next = BUS_IDLE;
      default:
        bus_state_next = BUS_IDLE;
    endcase
  end

  // State register of the bus sequencer
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      bus_state_reg <= BUS_IDLE;
    else
      bus_state_reg <= bus_state_next;
  end

  // Read data for the addressed word
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    err_next = ~mapped;
    if (mapped && !PWRITE)
    begin
      case (word_idx)
        IDX_OUTPUT0:
          rdata_next = chan_reg[0];
        IDX_OUTPUT1:
          rdata_next = chan_reg[1];
        IDX_OUTPUT2:
          rdata_next = chan_reg[2];
        IDX_OUTPUT3:
          rdata_next = chan_reg[3];
        IDX_LOCK_PRESCALE:
          rdata_next = prescale_reg;
        IDX_PLL_CONTROL:
          rdata_next = pll_ctrl_reg;
        IDX_FEEDBACK_DIV:
          rdata_next = feedback_reg;
        IDX_STATUS:
          rdata_next = {24'h00_0000, pin_sync_reg[2], pin_sync_reg[1], 2'h0,
                        eff_enable};
        default:
          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Registered answer: ready, read data and error together
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else if (bus_state_next == BUS_WAIT)
    begin
      PREADY <= 1'b1;
      PRDATA <= rdata_next;
      PSLVERR <= err_next;
    end
    else
    begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
  end

  // Channel words, one per output in ascending order
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++)
    begin : g_chan
      always_ff @(posedge MCLK or posedge RST)
      begin
        if (RST)
          chan_reg[ch] <= CHANNEL_RESET;
        else if (soft_reset)
          chan_reg[ch] <= CHANNEL_RESET;
        else if (wr_commit && word_idx == IDX_OUTPUT0 + 6'(ch))
          chan_reg[ch] <= PWDATA & CHANNEL_MASK;
      end

      // Enable after global bit and gate pin
      assign eff_enable[ch] = chan_reg[ch][CH_ENABLE_BIT]
                              & all_outputs_enable & gate_level;

      coc_channel #(
        .TAPS(DELAY_TAPS)
      ) u_channel (
        .clk(MCLK),
        .rst(RST),
        .vco_level(vco_level),
        .vco_rise(vco_rise),
        .align_hold(align_hold),
        .path_sel(chan_reg[ch][PATH_SEL_LSB+:2]),
        .div_value(chan_reg[ch][DIV_VALUE_LSB+:8]),
        .delay_steps(chan_reg[ch][DELAY_LSB+:4]),
        .out_enable(eff_enable[ch]),
        .clk_out(ch_clk[ch])
      );
    end
  endgenerate

  // Lock detect prescale word
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      prescale_reg <= PRESCALE_RESET;
    else if (soft_reset)
      prescale_reg <= PRESCALE_RESET;
    else if (wr_commit && word_idx == IDX_LOCK_PRESCALE)
      prescale_reg <= PWDATA & PRESCALE_MASK;
  end

  // PLL control word, holds the global output enable
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      pll_ctrl_reg <= PLL_CONTROL_RESET;
    else if (soft_reset)
      pll_ctrl_reg <= PLL_CONTROL_RESET;
    else if (wr_commit && word_idx == IDX_PLL_CONTROL)
      pll_ctrl_reg <= PWDATA & PLL_CONTROL_MASK;
  end

  // Feedback divider word, stored for readback only
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
      feedback_reg <= FEEDBACK_RESET;
    else if (soft_reset)
      feedback_reg <= FEEDBACK_RESET;
    else if (wr_commit && word_idx == IDX_FEEDBACK_DIV)
      feedback_reg <= PWDATA & FEEDBACK_MASK;
  end

  // Global enable and lock detect prescale fields
  assign all_outputs_enable = pll_ctrl_reg[ALL_OUT_EN_BIT];
  assign lock_detect_prescale = prescale_reg[PRESCALE_BIT];

  // Two-flop synchronisers for the board pins
  // Pins are asynchronous, so only the second stage feeds logic
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pin_meta_reg <= 4'h0;
      pin_sync_reg <= 4'h0;
    end
    else
    begin
      pin_meta_reg <= {PD_FREQ_IN, ALIGN_N, OUTPUT_GATE_PIN, VCO_DIV_CLK};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Edge history for the two pin clocks
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      vco_prev_reg <= 1'b0;
      pd_prev_reg <= 1'b0;
    end
    else
    begin
      vco_prev_reg <= pin_sync_reg[0];
      pd_prev_reg <= pin_sync_reg[3];
    end
  end

  // Synced pin levels and rising edges
  assign vco_level = pin_sync_reg[0];
  assign vco_rise = pin_sync_reg[0] & ~vco_prev_reg;
  assign gate_level = pin_sync_reg[1];
  assign align_hold = ~pin_sync_reg[2];
  assign pd_level = pin_sync_reg[3];
  assign pd_rise = pin_sync_reg[3] & ~pd_prev_reg;

  // Lock detect clock: straight through or divided by four
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      pre_cnt_reg <= 1'h0;
      pre_div_reg <= 1'b0;
    end
    else if (!lock_detect_prescale)
    begin
      pre_cnt_reg <= 1'h0;
      pre_div_reg <= 1'b0;
    end
    else if (pd_rise)
    begin
      if (pre_cnt_reg == PRESCALE_TOGGLE_LAST)
      begin
        pre_cnt_reg <= 1'h0;
        pre_div_reg <= ~pre_div_reg;
      end
      else
      begin
        pre_cnt_reg <= pre_cnt_reg + 1'h1;
      end
    end
  end

  // Output flops
  always_ff @(posedge MCLK or posedge RST)
  begin
    if (RST)
    begin
      CLK_OUT <= '0;
      LOCK_DETECT_CLK <= 1'b0;
    end
    else
    begin
      CLK_OUT <= ch_clk;
      LOCK_DETECT_CLK <= lock_detect_prescale ? pre_div_reg : pd_level;
    end
  end

endmodule
`default_nettype wire

//--- verilog/coc_pkg.sv
`default_nettype none
// Shared constants for the clock output channel configuration block
package coc_pkg;

  // Bus and channel widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned DELAY_TAPS = 16;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_RESET_WORD = 6'h00;
  localparam logic [5:0] IDX_OUTPUT0 = 6'h04;
  localparam logic [5:0] IDX_OUTPUT1 = 6'h05;
  localparam logic [5:0] IDX_OUTPUT2 = 6'h06;
  localparam logic [5:0] IDX_OUTPUT3 = 6'h07;
  localparam logic [5:0] IDX_LOCK_PRESCALE = 6'h0B;
  localparam logic [5:0] IDX_PLL_CONTROL = 6'h0E;
  localparam logic [5:0] IDX_FEEDBACK_DIV = 6'h0F;
  localparam logic [5:0] IDX_STATUS = 6'h10;

  // Field positions
  localparam int unsigned SOFT_RESET_BIT = 31;
  localparam int unsigned PATH_SEL_LSB = 17;
  localparam int unsigned CH_ENABLE_BIT = 16;
  localparam int unsigned DIV_VALUE_LSB = 8;
  localparam int unsigned DELAY_LSB = 4;
  localparam int unsigned PRESCALE_BIT = 15;
  localparam int unsigned ALL_OUT_EN_BIT = 27;

  // Writable bits of each word
  localparam logic [31:0] CHANNEL_MASK = 32'h0007_FFF0;
  localparam logic [31:0] PRESCALE_MASK = 32'h0000_8000;
  localparam logic [31:0] PLL_CONTROL_MASK = 32'h0FFF_FF00;
  localparam logic [31:0] FEEDBACK_MASK = 32'hC3FF_FF00;

  // Values after reset
  localparam logic [31:0] CHANNEL_RESET = 32'h0000_0100;
  localparam logic [31:0] PRESCALE_RESET = 32'h0000_0000;
  localparam logic [31:0] PLL_CONTROL_RESET = 32'h0800_0A00;
  localparam logic [31:0] FEEDBACK_RESET = 32'h0002_F800;

  // Path select codes
  localparam logic [1:0] PATH_BYPASS = 2'h0;
  localparam logic [1:0] PATH_DIVIDED = 2'h1;
  localparam logic [1:0] PATH_DELAYED = 2'h2;
  localparam logic [1:0] PATH_BOTH = 2'h3;

  // Lock detect prescale ratio, as a toggle count
  localparam logic [0:0] PRESCALE_TOGGLE_LAST = 1'h1;

  // Bus transfer states
  typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} coc_bus_e;

endpackage
`default_nettype wire

//--- verilog/coc_channel.sv
`default_nettype none
// One clock output channel: even divider, tap delay line, path mux, gate
module coc_channel
  import coc_pkg::*;
#(
  parameter int unsigned TAPS = coc_pkg::DELAY_TAPS
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Shared VCO divider output and align hold
  input wire logic vco_level,
  input wire logic vco_rise,
  input wire logic align_hold,
  // Channel settings
  input wire logic [1:0] path_sel,
  input wire logic [7:0] div_value,
  input wire logic [3:0] delay_steps,
  input wire logic out_enable,
  // Channel clock
  output logic clk_out
);

  import coc_pkg::*;

  logic [7:0] cnt_reg;
  logic div_reg;
  logic [TAPS-1:0] line_reg;
  logic src;
  logic routed;

  // Divide by twice the value, stepped by the VCO divider edge
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_reg <= 8'h00;
      div_reg <= 1'b0;
    end
    else if (align_hold)
    begin
      cnt_reg <= 8'h00;
      div_reg <= 1'b0;
    end
    else if (vco_rise && div_value != 8'h00 && path_sel[0])
    begin
      if (cnt_reg == div_value - 8'h01)
      begin
        cnt_reg <= 8'h00;
        div_reg <= ~div_reg;
      end
      else
      begin
        cnt_reg <= cnt_reg + 8'h01;
      end
    end
  end

  // Divider is in the path only for divided codes
  assign src = path_sel[0] ? div_reg : vco_level;

  // Delay line, one tap per step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      line_reg <= '0;
    end
    else
    begin
      line_reg <= {line_reg[TAPS-2:0], src};
    end
  end

  // Delay is in the path only for delayed codes
  assign routed = path_sel[1] ? line_reg[delay_steps] : src;

  // Gated output flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clk_out <= 1'b0;
    end
    else
    begin
      clk_out <= out_enable & routed;
    end
  end

endmodule
`default_nettype wire

//--- bench/coc_config_checker_assertions.sv
`default_nettype none
// Port-level checks of the configuration block
module coc_config_checker
  import coc_pkg::*;
(
  // Clock and reset
  input wire logic MCLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [coc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [coc_pkg::DATA_W-1:0] PWDATA,
  input wire logic [coc_pkg::DATA_W-1:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Board pins
  input wire logic OUTPUT_GATE_PIN,
  input wire logic [coc_pkg::NUM_CH-1:0] CLK_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (RST);

  // Bus answer shape
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held too long");
  property p_err_ready;
    PSLVERR |-> PREADY;
  endproperty
  a_err_ready: assert property (p_err_ready)
    else $error("error without ready");
  property p_rdata_idle;
    !PREADY |-> PRDATA == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside answer");
  property p_ready_cause;
    PREADY |-> PSEL && PENABLE;
  endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("ready without access");
  property p_answer;
    PSEL && $rose(PENABLE) |=> PREADY;
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer late");
  property p_unaligned;
    PSEL && $rose(PENABLE) && PADDR[1:0] != 2'h0 |=> PSLVERR && PRDATA == 32'h0;
  endproperty
  a_unaligned: assert property (p_unaligned)
    else $error("unaligned access accepted");

  // Output gating
  property p_gate_off;
    !OUTPUT_GATE_PIN [*8] |-> CLK_OUT == 4'h0;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("output on while gate low");
  property p_soft_reset;
    PREADY && !PSLVERR && PWRITE && PADDR == 8'h00 && PWDATA[31] |-> ##[1:24] CLK_OUT == 4'h0;
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("outputs live after soft reset");
endmodule

bind coc_config_top coc_config_checker coc_config_checker_i (.MCLK, .RST, .PSEL, .PENABLE,
  .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .OUTPUT_GATE_PIN, .CLK_OUT);
`default_nettype wire

//--- bench/coc_board_model.sv
`default_nettype none
// Free-running VCO divider and phase detector clocks on the board
module coc_board_model
#(
  parameter int VCO_HALF_NS = 1000,
  parameter int PD_HALF_NS = 400
)
(
  // Board clocks
  output logic vco_clk,
  output logic pd_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Shared VCO divider output, off phase with the system clock
  initial
  begin
    vco_clk = 1'b0;
    #13;
    forever #VCO_HALF_NS vco_clk = ~vco_clk;
  end
  // Phase detector rate
  initial
  begin
    pd_clk = 1'b0;
    #7;
    forever #PD_HALF_NS pd_clk = ~pd_clk;
  end
endmodule
`default_nettype wire

//--- bench/test_clock_output_channel_config.sv
`default_nettype none
module test_clock_output_channel_config;
  timeunit 1ns;
  timeprecision 1ps;
  import coc_pkg::*;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic vco, gate, align_n, pd, ld;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] clk_out;
  logic [4:0] prv;
  wire logic [4:0] cur = {ld, clk_out};
  int cnt[5], base[5], n, n_errors, num_checks;

  // Block and board
  coc_config_top coc_config_top_i (.MCLK(mclk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .VCO_DIV_CLK(vco), .OUTPUT_GATE_PIN(gate), .ALIGN_N(align_n),
    .PD_FREQ_IN(pd), .CLK_OUT(clk_out), .LOCK_DETECT_CLK(ld));
  coc_board_model coc_board_model_i (.vco_clk(vco), .pd_clk(pd));

  // System clock
  always #25 mclk = ~mclk;

  // Rising edges of each output
  always @(posedge mclk)
  begin
    prv <= cur;
    for (int i = 0; i < 5; i++)
      if (cur[i] && !prv[i])
        cnt[i] <= cnt[i] + 1;
  end

  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Edge counts over eight VCO periods
  task win(input int e[5]);
    base = cnt;
    repeat (320) @(posedge mclk);
    for (int i = 0; i < 5; i++)
      chk(32'(cnt[i] - base[i]), 32'(e[i]));
  endtask

  task stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    stop_test;
  end

  // Test sequence
  initial
  begin
    mclk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata, prv} = '0;
    {gate, align_n} = 2'h3;
    cnt = '{default: 0};
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++)
      rdc(8'h10 + 8'(4 * i), 32'h0000_0100);
    rdc(8'h2C, 32'h0);
    rdc(8'h38, 32'h0800_0A00);
    rdc(8'h3C, 32'h0002_F800);
    $display("test defaults done");
    xfer(1'b1, 8'h10, 32'h7FFF_FFFF);
    rdc(8'h10, 32'h0007_FFF0);
    rdc(8'h14, 32'h0000_0100);
    xfer(1'b0, 8'h44, 32'h0);
    chk({31'h0, er}, 32'h1);
    xfer(1'b1, 8'h12, 32'h0);
    chk({31'h0, er}, 32'h1);
    rdc(8'h10, 32'h0007_FFF0);
    $display("test access done");
    // One path code per channel, then align
    xfer(1'b1, 8'h10, 32'h0001_0100);
    xfer(1'b1, 8'h14, 32'h0003_0100);
    xfer(1'b1, 8'h18, 32'h0005_01F0);
    xfer(1'b1, 8'h1C, 32'h0007_0200);
    align_n <= 1'b0;
    repeat (4) @(posedge mclk);
    align_n <= 1'b1;
    repeat (100) @(posedge mclk);
    rdc(8'h40, 32'hCF);
    win('{8, 4, 8, 2, 20});
    do @(posedge mclk); while (!(clk_out[0] && !prv[0]));
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!(clk_out[2] && !prv[2]));
    chk(32'(n), 32'd16);
    $display("test paths done");
    // Gate pin, prescale, global bit
    gate <= 1'b0;
    xfer(1'b1, 8'h2C, 32'h0000_8000);
    repeat (30) @(posedge mclk);
    rdc(8'h40, 32'h80);
    win('{0, 0, 0, 0, 5});
    gate <= 1'b1;
    xfer(1'b1, 8'h38, 32'h0000_0A00);
    repeat (30) @(posedge mclk);
    rdc(8'h40, 32'hC0);
    win('{0, 0, 0, 0, 5});
    $display("test gating done");
    // Soft reset with other bits set
    xfer(1'b1, 8'h38, 32'h0800_0B00);
    xfer(1'b1, 8'h00, 32'h8801_FFF0);
    for (int i = 0; i < 4; i++)
      rdc(8'h10 + 8'(4 * i), 32'h0000_0100);
    rdc(8'h2C, 32'h0);
    rdc(8'h38, 32'h0800_0A00);
    rdc(8'h00, 32'h0);
    repeat (30) @(posedge mclk);
    rdc(8'h40, 32'hC0);
    $display("test soft reset done");
    stop_test;
  end
endmodule
`default_nettype wire
